// ### core/sfec_regs.svh
// Constants for the serial flash erase control block.
// Assumes SPI mode 0 on the link, sampled by a 20 MHz system clock.
`ifndef SFEC_REGS_SVH
`define SFEC_REGS_SVH
`define SFEC_OP_SE          8'hD8
`define SFEC_OP_SE4         8'hDC
`define SFEC_OP_BE1         8'h60
`define SFEC_OP_BE2         8'hC7
`define SFEC_OP_PAUSE       8'h75
`define SFEC_OP_CONT        8'h7A
`define SFEC_OP_WRITE_UNLOCK_CMD        8'h06
`define SFEC_OP_WRDI        8'h04
`define SFEC_OP_READ_STATUS_ONE_CMD       8'h05
`define SFEC_OP_READ_STATUS_TWO_CMD       8'h07
`define SFEC_OP_WRR         8'h01
`define SFEC_OP_BANK_REGISTER_ACCESS_CMD        8'hB9
`define SFEC_OP_PPBE        8'hE4
`define SFEC_OP_PP          8'h02
`define SFEC_OP_PP4         8'h12
`define SFEC_OP_CLSR        8'h30
`define SFEC_BITS_OP        6'd8
`define SFEC_BITS_A3        6'd32
`define SFEC_BITS_A4        6'd40
`define SFEC_BITS_WRR       6'd16
`define SFEC_SECT_LSB       18
`define SFEC_SECTORS        256
`define SFEC_CLK_MHZ        20
`define SFEC_ESL_US         45
`define SFEC_ESL_CYC        (`SFEC_ESL_US * `SFEC_CLK_MHZ)
`define SFEC_PREPGM_CYC     16'd64
`define SFEC_ERASE_CYC      16'd256
`define SFEC_PROG_CYC       16'd32
`define SFEC_SR1_WIP        0
`define SFEC_SR1_WEL        1
`define SFEC_SR1_EERR       5
`define SFEC_SR1_PERR       6
`define SFEC_SR2_ESUS       1
`endif

// ### core/sfec_pkg.sv
// Types shared by the erase control block.
// Assumes sfec_regs.svh supplies the numbers.
package sfec_pkg;
    typedef enum logic [2:0] {
        SFEC_IDLE, SFEC_PREPGM, SFEC_ERASE, SFEC_PAUSING, SFEC_SUSP, SFEC_PROG
    } sfec_state_e;
    typedef logic [7:0] sfec_byte_t;
endpackage

// ### core/sfec_sync.sv
// Three-stage synchroniser with agreement filter.
// Assumes input is asynchronous to sys_clk_i.
`timescale 1ns/1ps
module sfec_sync (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Pin in, filtered level out
    input  wire logic pin_i,
    input  wire logic init_i,
    output logic      level_o
);
    logic [2:0] stg_q;
    logic [2:0] stg_d;
    logic       lvl_q;
    logic       lvl_d;
    always_comb begin
        stg_d = {stg_q[1:0], pin_i};
        // Only stages two and three vote; stage one feeds nothing else
        lvl_d = (stg_q[1] == stg_q[2]) ? stg_q[2] : lvl_q;
    end
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stg_q <= 3'h7;
            lvl_q <= 1'b1;
        end else begin
            stg_q <= stg_d;
            lvl_q <= lvl_d;
        end
    end
    assign level_o = lvl_q;
    logic unused_init;
    assign unused_init = init_i;
endmodule

// ### core/sfec_shift.sv
// SPI input shifter: counts bits of a frame, keeps last bytes.
// Assumes clock and chip select already synchronised.
`timescale 1ns/1ps
module sfec_shift
    import sfec_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Synchronised link
    input  wire logic       cs_n_i,
    input  wire logic       sck_rise_i,
    input  wire logic       si_i,
    // Frame contents
    output logic [5:0]      bit_cnt_o,
    output sfec_byte_t      opcode_o,
    output logic [31:0]     addr_o
);
    `include "sfec_regs.svh"
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_d;
    logic [39:0] sh_q;
    logic [39:0] sh_d;
    always_comb begin
        cnt_d = cnt_q;
        sh_d  = sh_q;
        if (cs_n_i) begin
            cnt_d = 6'd0;
        end else if (sck_rise_i) begin
            // Saturate so long frames never alias a short one
            if (cnt_q != 6'h3F) begin
                cnt_d = cnt_q + 6'd1;
            end
            sh_d = {sh_q[38:0], si_i};
        end
    end
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 6'd0;
            sh_q  <= 40'h00_0000_0000;
        end else begin
            cnt_q <= cnt_d;
            sh_q  <= sh_d;
        end
    end
    // Opcode sits at a depth set by bit count; caller picks by count
    always_comb begin
        opcode_o = sh_q[7:0];
        addr_o   = sh_q[31:0];
        if (cnt_q == `SFEC_BITS_A4) begin
            opcode_o = sh_q[39:32];
        end else if (cnt_q == `SFEC_BITS_A3) begin
            opcode_o = sh_q[31:24];
            addr_o   = {8'h00, sh_q[23:0]};
        end else if (cnt_q == `SFEC_BITS_WRR) begin
            opcode_o = sh_q[15:8];
        end
    end
    assign bit_cnt_o = cnt_q;
endmodule

// ### core/sfec_top.sv
// Erase sequencer: decodes erase, suspend and resume frames off SPI.
// Assumes SPI mode 0 pins asynchronous to sys_clk_i; array cells outside.
`timescale 1ns/1ps
`include "sfec_regs.svh"
module sfec_top
    import sfec_pkg::*;
#(
    parameter int ESL_CYC = `SFEC_ESL_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // SPI link pins
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic        si_i,
    // Configuration and protection
    input  wire logic        four_byte_address_select_i,
    input  wire logic [2:0]  block_protect_field_i,
    input  wire logic [255:0] persistent_protect_bit_i,
    input  wire logic [255:0] dynamic_protect_bit_i,
    input  wire logic [255:0] block_protect_map_i,
    // Status
    output logic             operation_in_progress_flag_o,
    output logic             write_unlock_latch_o,
    output logic             erase_error_o,
    output logic             program_error_o,
    output logic             erase_suspended_o,
    output logic [7:0]       status_register_one_o,
    output logic [7:0]       status_register_two_o,
    // Array control
    output logic             erase_strobe_o,
    output logic             prepgm_active_o,
    output logic             erase_active_o,
    output logic [7:0]       erase_sector_o,
    output logic             erase_all_o,
    output logic [255:0]     erase_skip_o,
    output logic             read_undefined_o,
    output logic             bank_write_o,
    output logic             status_write_o,
    output logic             prog_strobe_o,
    output logic [7:0]       last_read_cmd_o
);
    `include "sfec_regs.svh"

    logic cs_s;
    logic sck_s;
    logic si_s;
    logic sck_prev_q;
    logic cs_prev_q;
    logic [5:0]  bit_cnt;
    sfec_byte_t  opcode;
    logic [31:0] addr;

    sfec_sync u_sync_cs  (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pin_i(cs_n_i), .init_i(1'b1), .level_o(cs_s));
    sfec_sync u_sync_sck (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pin_i(sck_i),  .init_i(1'b1), .level_o(sck_s));
    sfec_sync u_sync_si  (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pin_i(si_i),   .init_i(1'b1), .level_o(si_s));

    sfec_shift u_shift (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .cs_n_i    (cs_s),
        .sck_rise_i(sck_s & ~sck_prev_q),
        .si_i      (si_s),
        .bit_cnt_o (bit_cnt),
        .opcode_o  (opcode),
        .addr_o    (addr)
    );

    // Protection lookup used by the sector erase check only; program check compares sector
    function automatic logic sect_prot(input logic [7:0] s, input logic [255:0] bp,
                                       input logic [255:0] persistent_protect_bit, input logic [255:0] dynamic_protect_bit);
        sect_prot = bp[s] | persistent_protect_bit[s] | dynamic_protect_bit[s];
    endfunction

    logic frame_end;
    assign frame_end = cs_s & ~cs_prev_q;

    sfec_state_e st_q, st_d;
    logic [15:0] tmr_q, tmr_d;
    logic [15:0] pause_q, pause_d;
    logic [7:0]  sect_q, sect_d;
    logic        all_q, all_d;
    logic        wel_q, wel_d;
    logic        eerr_q, eerr_d;
    logic        perr_q, perr_d;
    logic        esus_q, esus_d;
    logic        bank_register_access_cmd_q, bank_register_access_cmd_d;
    logic        strobe_q, strobe_d;
    logic        pstrobe_q, pstrobe_d;
    logic        bankw_q, bankw_d;
    logic        statw_q, statw_d;
    logic [7:0]  rdcmd_q, rdcmd_d;
    logic [255:0] skip_q, skip_d;
    logic [7:0]  psect;
    logic        addr_len_ok;

    assign psect = addr[`SFEC_SECT_LSB +: 8];

    always_comb begin
        // D8h length follows address setting; DCh always four bytes
        addr_len_ok = 1'b0;
        if (opcode == `SFEC_OP_SE4) begin
            addr_len_ok = (bit_cnt == `SFEC_BITS_A4);
        end else if (opcode == `SFEC_OP_SE) begin
            addr_len_ok = four_byte_address_select_i ? (bit_cnt == `SFEC_BITS_A4)
                                                     : (bit_cnt == `SFEC_BITS_A3);
        end
    end

    always_comb begin
        st_d = st_q; tmr_d = tmr_q; pause_d = pause_q; sect_d = sect_q;
        all_d = all_q; wel_d = wel_q; eerr_d = eerr_q; perr_d = perr_q;
        esus_d = esus_q; bank_register_access_cmd_d = bank_register_access_cmd_q; strobe_d = 1'b0; pstrobe_d = 1'b0;
        bankw_d = 1'b0; statw_d = 1'b0; rdcmd_d = rdcmd_q; skip_d = skip_q;
        // Internal cycle timers
        unique case (st_q)
            SFEC_IDLE, SFEC_SUSP: begin
            end
            SFEC_PREPGM: begin
                if (tmr_q == 16'd0) begin
                    st_d  = SFEC_ERASE;
                    tmr_d = `SFEC_ERASE_CYC;
                end else begin
                    tmr_d = tmr_q - 16'd1;
                end
            end
            SFEC_ERASE: begin
                if (tmr_q == 16'd0) begin
                    st_d = SFEC_IDLE;
                    all_d = 1'b0;
                end else begin
                    tmr_d = tmr_q - 16'd1;
                end
            end
            SFEC_PAUSING: begin
                // Fixed latency well under the limit; remaining work kept in tmr
                if (pause_q == 16'd0) begin
                    st_d   = SFEC_SUSP;
                    esus_d = 1'b1;
                end else begin
                    pause_d = pause_q - 16'd1;
                end
            end
            SFEC_PROG: begin
                if (tmr_q == 16'd0) begin
                    st_d  = SFEC_SUSP;
                    tmr_d = pause_q;
                end else begin
                    tmr_d = tmr_q - 16'd1;
                end
            end
        endcase
        if (frame_end) begin
            if (bit_cnt == `SFEC_BITS_OP) begin
                bank_register_access_cmd_d = (opcode == `SFEC_OP_BANK_REGISTER_ACCESS_CMD);
                unique case (opcode)
                    `SFEC_OP_WRITE_UNLOCK_CMD: wel_d = 1'b1;
                    `SFEC_OP_WRDI: wel_d = 1'b0;
                    `SFEC_OP_CLSR: begin
                        eerr_d = 1'b0;
                        perr_d = 1'b0;
                    end
                    `SFEC_OP_READ_STATUS_ONE_CMD, `SFEC_OP_READ_STATUS_TWO_CMD: rdcmd_d = opcode;
                    `SFEC_OP_BE1, `SFEC_OP_BE2: begin
                        // Eighth bit exactly, latch set, no block protection
                        if (st_q == SFEC_IDLE && wel_q && block_protect_field_i == 3'h0) begin
                            st_d = SFEC_PREPGM; tmr_d = `SFEC_PREPGM_CYC;
                            all_d = 1'b1; strobe_d = 1'b1;
                            skip_d = persistent_protect_bit_i | dynamic_protect_bit_i;
                        end
                        if (block_protect_field_i == 3'h0) begin
                            wel_d = 1'b0;
                        end
                    end
                    `SFEC_OP_PAUSE: begin
                        // Bulk erase never pauses
                        if ((st_q == SFEC_PREPGM || st_q == SFEC_ERASE) && !all_q) begin
                            st_d = SFEC_PAUSING;
                            pause_d = 16'(ESL_CYC / 64);
                        end
                    end
                    `SFEC_OP_CONT: begin
                        if (st_q == SFEC_SUSP) begin
                            st_d = SFEC_ERASE;
                            esus_d = 1'b0;
                        end
                    end
                    `SFEC_OP_PPBE: begin
                        if (st_q == SFEC_IDLE && wel_q) begin
                            wel_d = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (addr_len_ok) begin
                bank_register_access_cmd_d = 1'b0;
                if (st_q == SFEC_IDLE && wel_q) begin
                    wel_d = 1'b0;
                    if (sect_prot(psect, block_protect_map_i, persistent_protect_bit_i, dynamic_protect_bit_i)) begin
                        eerr_d = 1'b1;
                    end else begin
                        st_d = SFEC_PREPGM; tmr_d = `SFEC_PREPGM_CYC;
                        sect_d = psect; strobe_d = 1'b1;
                        skip_d = '0;
                    end
                end
            end else if (bit_cnt == `SFEC_BITS_WRR && opcode == `SFEC_OP_WRR) begin
                if (st_q == SFEC_SUSP && bank_register_access_cmd_q) begin
                    bankw_d = 1'b1;
                end else if (st_q == SFEC_IDLE && wel_q) begin
                    statw_d = 1'b1; wel_d = 1'b0;
                end
                bank_register_access_cmd_d = 1'b0;
            end else if (bit_cnt >= `SFEC_BITS_A3 && (opcode == `SFEC_OP_PP || opcode == `SFEC_OP_PP4)
                         && st_q == SFEC_SUSP && wel_q) begin
                wel_d = 1'b0; bank_register_access_cmd_d = 1'b0;
                if (psect == sect_q) begin
                    perr_d = 1'b1;
                end else begin
                    st_d = SFEC_PROG; pstrobe_d = 1'b1;
                    pause_d = tmr_q; tmr_d = `SFEC_PROG_CYC;
                end
            end else begin
                bank_register_access_cmd_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= SFEC_IDLE; tmr_q <= 16'h0000; pause_q <= 16'h0000;
            sect_q <= 8'h00; all_q <= 1'b0; wel_q <= 1'b0; eerr_q <= 1'b0;
            perr_q <= 1'b0; esus_q <= 1'b0; bank_register_access_cmd_q <= 1'b0; strobe_q <= 1'b0;
            pstrobe_q <= 1'b0; bankw_q <= 1'b0; statw_q <= 1'b0; rdcmd_q <= 8'h00;
            skip_q <= '0; sck_prev_q <= 1'b0; cs_prev_q <= 1'b1;
        end else begin
            st_q <= st_d; tmr_q <= tmr_d; pause_q <= pause_d;
            sect_q <= sect_d; all_q <= all_d; wel_q <= wel_d; eerr_q <= eerr_d;
            perr_q <= perr_d; esus_q <= esus_d; bank_register_access_cmd_q <= bank_register_access_cmd_d; strobe_q <= strobe_d;
            pstrobe_q <= pstrobe_d; bankw_q <= bankw_d; statw_q <= statw_d; rdcmd_q <= rdcmd_d;
            skip_q <= skip_d; sck_prev_q <= sck_s; cs_prev_q <= cs_s;
        end
    end

    logic operation_in_progress_flag;
    assign operation_in_progress_flag = (st_q == SFEC_PREPGM) || (st_q == SFEC_ERASE) || (st_q == SFEC_PAUSING) || (st_q == SFEC_PROG);

    assign operation_in_progress_flag_o = operation_in_progress_flag;
    assign write_unlock_latch_o  = wel_q;
    assign erase_error_o         = eerr_q;
    assign program_error_o       = perr_q;
    assign erase_suspended_o     = esus_q;
    assign status_register_one_o = {1'b0, perr_q, eerr_q, 3'h0, wel_q, operation_in_progress_flag};
    assign status_register_two_o = {6'h00, esus_q, 1'b0};
    assign erase_strobe_o        = strobe_q;
    assign prepgm_active_o       = (st_q == SFEC_PREPGM);
    assign erase_active_o        = (st_q == SFEC_ERASE);
    assign erase_sector_o        = sect_q;
    assign erase_all_o           = all_q;
    assign erase_skip_o          = skip_q;
    assign read_undefined_o      = esus_q;
    assign bank_write_o          = bankw_q;
    assign status_write_o        = statw_q;
    assign prog_strobe_o         = pstrobe_q;
    assign last_read_cmd_o       = rdcmd_q;

    chk_wip_state: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        strobe_q |-> operation_in_progress_flag_o) else $error("busy not set on erase start");
    chk_bulk_nopause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        all_q |-> st_q != SFEC_PAUSING) else $error("bulk erase paused");
    chk_prepgm_first: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        strobe_q |-> st_q == SFEC_PREPGM) else $error("erase skipped pre-program");
    chk_perr_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(perr_q) |-> $past(st_q) == SFEC_SUSP) else $error("program error outside suspend");
    chk_susp_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_q == SFEC_SUSP) |-> esus_q) else $error("suspend flag low while suspended");
    chk_cont_wip: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(esus_q) |-> operation_in_progress_flag) else $error("resume did not raise busy");
    chk_bank_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        statw_q |-> $past(st_q) == SFEC_IDLE) else $error("status written during suspend");
    chk_wel_needed: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        strobe_q |-> $past(wel_q)) else $error("erase without write latch");
endmodule

// ### tb/sfec_host_model.sv
// SPI host model: mode 0 frames, MSB first, SCK of 8 bench cycles.
// Assumes sys_clk_i is the 20 MHz bench clock; pins change at its falling edge.
`timescale 1ns/1ps
module sfec_host_model (
    // Bench clock
    input  wire logic sys_clk_i,
    // SPI link pins
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end
    // Count given by caller, so short or long frames can be made on purpose
    task automatic frame(input logic [39:0] data, input int nbits);
        @(negedge sys_clk_i);
        cs_n_o = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            si_o = data[i];
            repeat (4) @(negedge sys_clk_i);
            sck_o = 1'b1;
            repeat (4) @(negedge sys_clk_i);
            sck_o = 1'b0;
        end
        repeat (2) @(negedge sys_clk_i);
        cs_n_o = 1'b1;
        // Released line flips so a stale level is never mistaken for data
        si_o = ~si_o;
        repeat (16) @(negedge sys_clk_i);
    endtask
endmodule

// ### tb/tb_top.sv
// Bench for the erase sequencer, driven through the SPI host model.
// Assumes core/ files compiled first; SCK stands still between frames.
`timescale 1ns/1ps
module tb_top;
    import sfec_pkg::*;
    localparam int ESL = 640;
    logic         sys_clk_i;
    logic         rst_i;
    logic         cs_n, sck, si, ext4;
    logic [2:0]   bp;
    logic [255:0] persistent_protect_bit, dynamic_protect_bit, bpm, skip;
    logic         busy, write_unlock_latch, eerr, perr, esus, strobe, prepgm, eact, eall, rdund, bankw, statw, progs;
    logic [7:0]   sr1, sr2, esect, lastrd;
    int           fail_count, comparisons, cyc, n_erase, n_prog, n_bank, n_stat, e0, b0;

    sfec_host_model i_host (.sys_clk_i(sys_clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

    sfec_top #(.ESL_CYC(ESL)) i_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .four_byte_address_select_i(ext4), .block_protect_field_i(bp),
        .persistent_protect_bit_i(persistent_protect_bit), .dynamic_protect_bit_i(dynamic_protect_bit), .block_protect_map_i(bpm),
        .operation_in_progress_flag_o(busy), .write_unlock_latch_o(write_unlock_latch), .erase_error_o(eerr),
        .program_error_o(perr), .erase_suspended_o(esus), .status_register_one_o(sr1),
        .status_register_two_o(sr2), .erase_strobe_o(strobe), .prepgm_active_o(prepgm),
        .erase_active_o(eact), .erase_sector_o(esect), .erase_all_o(eall), .erase_skip_o(skip),
        .read_undefined_o(rdund), .bank_write_o(bankw), .status_write_o(statw),
        .prog_strobe_o(progs), .last_read_cmd_o(lastrd)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // Pulses are one cycle wide, so they are tallied rather than sampled
    always @(posedge sys_clk_i) begin
        cyc++;
        if (strobe === 1'b1) n_erase++;
        if (progs === 1'b1) n_prog++;
        if (bankw === 1'b1) n_bank++;
        if (statw === 1'b1) n_stat++;
        if (cyc == 40000) begin
            fail_count++;
            $display("BAD run length expected below 40000 seen %0d", cyc);
            summarize();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wait_busy(input logic v, input int max);
        int n;
        n = 0;
        while (busy !== v && n < max) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk("busy level", {31'h0, v}, {31'h0, busy});
    endtask

    task automatic op(input logic [7:0] b);
        i_host.frame({32'h0, b}, 8);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        ext4  = 1'b0;
        bp    = 3'h0;
        persistent_protect_bit   = '0;
        dynamic_protect_bit   = '0;
        bpm   = '0;
        repeat (5) @(negedge sys_clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        chk("busy after reset", 32'h0, {31'h0, busy});
        i_host.frame(40'hD80C0000, 32);
        chk("erase without latch", 32'h0, n_erase);
        done("no_latch");

        op(8'h06);
        chk("latch", 32'h1, {31'h0, write_unlock_latch});
        i_host.frame(40'hD80C0000, 32);
        wait_busy(1'b1, 10);
        chk("sector", 32'h3, {24'h0, esect});
        chk("preprogram phase", 32'h1, {31'h0, prepgm});
        repeat (70) @(negedge sys_clk_i);
        chk("erase phase", 32'h1, {31'h0, eact});
        wait_busy(1'b0, 300);
        for (int k = 0; k < 2; k++) begin
            e0 = n_erase;
            op(8'h06);
            i_host.frame(k ? 40'h1B0180000 : 40'h6C060000, k ? 33 : 31);
            chk("erase on bad count", e0, n_erase);
        end
        for (int k = 0; k < 2; k++) begin
            ext4 = !k;
            op(8'h06);
            i_host.frame(k ? 40'hDC03000000 : 40'hD801040000, 40);
            wait_busy(1'b1, 10);
            chk("wide sector", k ? 32'hC0 : 32'h41, {24'h0, esect});
            wait_busy(1'b0, 400);
        end
        done("sector_erase");

        for (int k = 0; k < 3; k++) begin
            persistent_protect_bit[5] = (k == 0);
            dynamic_protect_bit[5] = (k == 1);
            bpm[5] = (k == 2);
            e0 = n_erase;
            op(8'h06);
            i_host.frame(40'hD8140000, 32);
            chk("protected start", e0, n_erase);
            chk("erase error", 32'h1, {31'h0, sr1[5]});
            op(8'h30);
            chk("error cleared", 32'h0, {31'h0, eerr});
        end
        persistent_protect_bit = '0;
        dynamic_protect_bit = '0;
        bpm = '0;
        done("protect");

        bp = 3'h2;
        e0 = n_erase;
        op(8'h06);
        op(8'h60);
        chk("bulk with field set", e0, n_erase);
        chk("no error", 32'h0, {31'h0, eerr});
        bp = 3'h0;
        op(8'h06);
        i_host.frame(40'hC0, 9);
        chk("bulk on bad count", e0, n_erase);
        dynamic_protect_bit[9] = 1'b1;
        op(8'h06);
        op(8'hC7);
        wait_busy(1'b1, 10);
        chk("whole array", 32'h1, {31'h0, eall});
        chk("skip map", 32'h2, {30'h0, skip[9:8]});
        op(8'h75);
        repeat (ESL / 64 + 10) @(negedge sys_clk_i);
        chk("pause in bulk", 32'h3, {30'h0, busy, ~esus});
        wait_busy(1'b0, 400);
        chk("skip error", 32'h0, {31'h0, eerr});
        dynamic_protect_bit = '0;
        done("bulk_erase");

        op(8'h06);
        i_host.frame(40'hD80C0000, 32);
        wait_busy(1'b1, 10);
        op(8'h75);
        wait_busy(1'b0, ESL / 64 + 8);
        chk("suspended flag", 32'h1, {31'h0, sr2[1]});
        chk("undefined read", 32'h1, {31'h0, rdund});
        op(8'h05);
        chk("status one read", 32'h05, {24'h0, lastrd});
        op(8'h07);
        chk("status two read", 32'h07, {24'h0, lastrd});
        b0 = n_stat;
        op(8'h06);
        i_host.frame(40'h0100, 16);
        op(8'h06);
        op(8'hB9);
        i_host.frame(40'h0100, 16);
        chk("register write", b0, n_stat);
        chk("bank write", 32'h1, n_bank);
        op(8'h06);
        i_host.frame(40'h12000C0000, 40);
        chk("program error", 32'h1, {31'h0, perr});
        op(8'h30);
        op(8'h06);
        i_host.frame(40'h0204000000, 40);
        chk("program start", 32'h1, n_prog);
        chk("program busy", 32'h1, {31'h0, busy});
        wait_busy(1'b0, 40);
        chk("back to suspend", 32'h1, {31'h0, esus});
        e0 = n_erase;
        // No second pause follows, so the interval before completion is kept
        op(8'h7A);
        chk("resumed", 32'h3, {30'h0, busy, ~esus});
        op(8'h7A);
        chk("repeat resume", e0, n_erase);
        wait_busy(1'b0, 400);
        op(8'h7A);
        chk("idle resume", 32'h0, {30'h0, busy, esus});
        done("suspend");
        summarize();
    end
endmodule
